// *** rtl/gw_pkg.sv ***
// constants and types shared by the sensor command gateway
package gw_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_MHZ = 125;
  localparam int BAUD_POS = 57600;
  localparam int BAUD_DIST = 38400;
  localparam logic [15:0] DIV_POS = 16'(CLK_HZ / BAUD_POS);
  localparam logic [15:0] DIV_DIST = 16'(CLK_HZ / BAUD_DIST);
  localparam int POLL_PERIOD_US = 10000;
  localparam int POLL_CYCLES = POLL_PERIOD_US * CLK_MHZ;
  localparam int POLL_CNT_W = 24;

  // register byte addresses
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_COMMAND = 5'h04;
  localparam logic [4:0] ADDR_STATUS = 5'h08;
  localparam logic [4:0] ADDR_RX_LO = 5'h0C;
  localparam logic [4:0] ADDR_RX_HI = 5'h10;
  localparam int CTRL_CMD_MODE_BIT = 0;
  localparam int CTRL_PROFILE_BIT = 1;
  localparam logic CMD_MODE_RST = 1'b0;
  localparam logic PROFILE_RST = 1'b0;

  localparam logic PROFILE_POS = 1'b0;
  localparam logic PROFILE_DIST = 1'b1;
  localparam logic [15:0] POS_CMD_MASK = 16'h001F;
  localparam logic [15:0] DIST_CMD_MASK = 16'h007F;
  localparam logic [3:0] POLL_CMD_BIT = 4'h3;
  localparam logic [1:0] POS_SEQ_LAST = 2'h1;
  localparam logic [1:0] DIST_SEQ_LAST = 2'h2;
  localparam logic [7:0] POS_CMD_UNIT = 8'h01;
  localparam logic [7:0] DIST_LEAD = 8'hC0;
  localparam logic [7:0] DIST_MID_BASE = 8'hF1;
  localparam logic [7:0] DIST_TAIL_BASE = 8'h31;
  localparam logic [2:0] TLG_LAST_DIST = 3'h5;
  localparam logic [2:0] TLG_LAST_POS = 3'h0;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  typedef enum logic [0:0] {SEQ_IDLE = 1'b0, SEQ_SEND = 1'b1} seq_state_t;
  typedef enum logic [1:0] {
    LN_IDLE = 2'b00,
    LN_START = 2'b01,
    LN_DATA = 2'b10,
    LN_STOP = 2'b11
  } line_state_t;
endpackage

// *** rtl/serial_link_if.sv ***
// byte stream and baud setting between command logic and serial engine
`timescale 1ns/100ps
interface serial_link_if;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [15:0] baud_div;
  modport engine(input tx_data, tx_valid, baud_div, output tx_ready, rx_data, rx_valid);
  modport ctrl(output tx_data, tx_valid, baud_div, input tx_ready, rx_data, rx_valid);
endinterface

// *** rtl/serial_engine.sv ***
// 8N1 serial transmitter and receiver, no handshake lines
`timescale 1ns/100ps
module serial_engine (
  input wire logic core_clk,
  input wire logic reset_n,
  serial_link_if.engine link,
  input wire logic rxd,
  output logic txd
);
  gw_pkg::line_state_t tx_st_r;
  gw_pkg::line_state_t rx_st_r;
  logic [15:0] tx_cnt_r;
  logic [15:0] rx_cnt_r;
  logic [2:0] tx_bit_r;
  logic [2:0] rx_bit_r;
  logic [7:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic rx_valid_r;
  logic txd_r;

  wire tx_tick = (tx_cnt_r == link.baud_div - 16'h0001);
  wire rx_tick = (rx_cnt_r == link.baud_div - 16'h0001);
  // receiver checks the start bit at mid-bit to reject glitches
  wire rx_half = (rx_cnt_r == (link.baud_div >> 1));

  assign link.tx_ready = (tx_st_r == gw_pkg::LN_IDLE);
  assign link.rx_data = rx_sh_r;
  assign link.rx_valid = rx_valid_r;
  assign txd = txd_r;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tx_st_r <= gw_pkg::LN_IDLE;
      tx_cnt_r <= 16'h0000;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      txd_r <= 1'b1;
    end else begin
      tx_cnt_r <= (tx_st_r == gw_pkg::LN_IDLE || tx_tick) ? 16'h0000 : tx_cnt_r + 16'h0001;
      case (tx_st_r)
        gw_pkg::LN_IDLE: if (link.tx_valid) begin // R1
          tx_sh_r <= link.tx_data;
          txd_r <= 1'b0;
          tx_st_r <= gw_pkg::LN_START;
        end
        gw_pkg::LN_START: if (tx_tick) begin
          txd_r <= tx_sh_r[0];
          tx_bit_r <= 3'h0;
          tx_st_r <= gw_pkg::LN_DATA;
        end
        gw_pkg::LN_DATA: if (tx_tick) begin
          tx_sh_r <= tx_sh_r >> 1;
          tx_bit_r <= tx_bit_r + 3'h1;
          txd_r <= (tx_bit_r == gw_pkg::LAST_DATA_BIT) ? 1'b1 : tx_sh_r[1];
          if (tx_bit_r == gw_pkg::LAST_DATA_BIT) tx_st_r <= gw_pkg::LN_STOP;
        end
        gw_pkg::LN_STOP: if (tx_tick) tx_st_r <= gw_pkg::LN_IDLE;
        default: tx_st_r <= gw_pkg::LN_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rx_st_r <= gw_pkg::LN_IDLE;
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= 1'b0;
      rx_cnt_r <= rx_cnt_r + 16'h0001;
      case (rx_st_r)
        gw_pkg::LN_IDLE: begin
          rx_cnt_r <= 16'h0000;
          if (!rxd) rx_st_r <= gw_pkg::LN_START;
        end
        gw_pkg::LN_START: if (rx_half) begin
          rx_cnt_r <= 16'h0000;
          rx_bit_r <= 3'h0;
          rx_st_r <= rxd ? gw_pkg::LN_IDLE : gw_pkg::LN_DATA;
        end
        gw_pkg::LN_DATA: if (rx_tick) begin
          rx_cnt_r <= 16'h0000;
          rx_sh_r <= {rxd, rx_sh_r[7:1]};
          rx_bit_r <= rx_bit_r + 3'h1;
          if (rx_bit_r == gw_pkg::LAST_DATA_BIT) rx_st_r <= gw_pkg::LN_STOP;
        end
        gw_pkg::LN_STOP: if (rx_tick) begin
          // a byte with a broken stop bit is dropped
          rx_valid_r <= rxd;
          rx_st_r <= gw_pkg::LN_IDLE;
        end
        default: rx_st_r <= gw_pkg::LN_IDLE;
      endcase
    end
  end
endmodule // serial_engine

// *** rtl/sensor_gateway.sv ***
// command translator: control bits to serial sensor commands, telegram capture
// Overview of operation
// R1: positioning link 57600 baud 8N1, no handshake
// R2: positioning data raw binary, unframed, unacknowledged
// R3: controller enables command mode via control bit 0
// R4: bit0 sends 01 01, bit1 sends 02 02
// R5: bit2 sends 04 04, bit3 sends 08 08
// R6: bit4 sends 10 10, bits 5-15 ignored
// R7: positioning profile polls position every 10 ms
// R8: polling resumes on position request or restart
// R9: positioning process data 20 in, 4 out
// R10: distance telegrams always exactly six bytes
// R11: distance link 38400 baud 8N1, unframed
// R12: bit0 sends C0F131, bit1 sends C0F232
// R13: bits 2-4 send C0F333, C0F434, C0F535
// R14: bit5 C0F636, bit6 C0F737, rest ignored
// R15: distance process data 20 in, 8 out
// R16: one send per rising bit, ascending order
`timescale 1ns/100ps
module sensor_gateway #(
  parameter int POLL_CYCLES = gw_pkg::POLL_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rxd,
  output logic txd
);
  serial_link_if link ();

  logic avs_waitrequest_r;
  logic [31:0] avs_readdata_r;
  logic cmd_mode_r;
  logic profile_select_switch_r;
  logic [15:0] cmd_r;
  logic [15:0] prev_cmd_r;
  logic [15:0] pend_r;
  logic auto_poll_r;
  logic poll_pend_r;
  logic [gw_pkg::POLL_CNT_W-1:0] poll_cnt_r;
  gw_pkg::seq_state_t seq_st_r;
  logic [3:0] sel_bit_r;
  logic [1:0] byte_idx_r;
  logic seq_prof_r;
  logic [47:0] rx_sh_r;
  logic [47:0] tlg_r;
  logic [2:0] rx_cnt_r;
  logic tlg_valid_r;
  logic [16:0] seen;
  logic [15:0] first_hot;
  logic [3:0] first_idx;

  // bus decode: a request is answered one edge after it appears
  wire req_new = (avs_read || avs_write) && avs_waitrequest_r;
  wire wr_acc = avs_write && !avs_waitrequest_r;
  wire rd_acc = avs_read && !avs_waitrequest_r;
  wire sel_control = (avs_address == gw_pkg::ADDR_CONTROL);
  wire sel_command = (avs_address == gw_pkg::ADDR_COMMAND);
  wire sel_status = (avs_address == gw_pkg::ADDR_STATUS);
  wire sel_rx_lo = (avs_address == gw_pkg::ADDR_RX_LO);
  wire sel_rx_hi = (avs_address == gw_pkg::ADDR_RX_HI);
  wire seq_busy = (seq_st_r == gw_pkg::SEQ_SEND);
  wire [31:0] status_word = {29'h0, tlg_valid_r, auto_poll_r, seq_busy};
  wire [31:0] control_word = {30'h0, profile_select_switch_r, cmd_mode_r};
  wire [31:0] rd_word =
    sel_control ? control_word :
    sel_command ? {16'h0, cmd_r} :
    sel_status ? status_word :
    sel_rx_lo ? tlg_r[31:0] :
    sel_rx_hi ? {16'h0, tlg_r[47:32]} : 32'h0;

  // command edges; bits without a function are masked off
  wire [15:0] cmd_mask = profile_select_switch_r ? gw_pkg::DIST_CMD_MASK : gw_pkg::POS_CMD_MASK;
  wire [15:0] cmd_rise = cmd_mode_r ? (cmd_r & ~prev_cmd_r & cmd_mask) : 16'h0; // R3 R6 R14 R16
  wire pos_prof = (profile_select_switch_r == gw_pkg::PROFILE_POS);
  wire poll_rise = cmd_rise[gw_pkg::POLL_CMD_BIT];
  wire other_rise = |(cmd_rise & ~(16'h1 << gw_pkg::POLL_CMD_BIT));
  wire poll_tick = (poll_cnt_r == gw_pkg::POLL_CNT_W'(POLL_CYCLES - 1));

  // lowest pending bit goes first
  genvar gi;
  assign seen[0] = 1'b0;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_prio
      assign first_hot[gi] = pend_r[gi] && !seen[gi];
      assign seen[gi + 1] = seen[gi] || pend_r[gi];
    end
  endgenerate

  always_comb begin
    first_idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (first_hot[i]) first_idx = 4'(i);
    end
  end

  wire seq_start_cmd = !seq_busy && (pend_r != 16'h0);
  wire seq_start_poll = !seq_busy && (pend_r == 16'h0) && poll_pend_r;
  wire seq_last = (byte_idx_r == (seq_prof_r ? gw_pkg::DIST_SEQ_LAST : gw_pkg::POS_SEQ_LAST));
  wire tx_acc = link.tx_valid && link.tx_ready;
  wire [7:0] dist_byte =
    (byte_idx_r == 2'h0) ? gw_pkg::DIST_LEAD :
    (byte_idx_r == 2'h1) ? gw_pkg::DIST_MID_BASE + {4'h0, sel_bit_r} :
    gw_pkg::DIST_TAIL_BASE + {4'h0, sel_bit_r}; // R12 R13 R14
  wire [7:0] pos_byte = 8'(gw_pkg::POS_CMD_UNIT << sel_bit_r); // R4 R5 R6 R2

  assign link.tx_valid = seq_busy;
  assign link.tx_data = seq_prof_r ? dist_byte : pos_byte;
  assign link.baud_div = pos_prof ? gw_pkg::DIV_POS : gw_pkg::DIV_DIST; // R1 R11

  wire [47:0] rx_window = {link.rx_data, rx_sh_r[47:8]};
  wire tlg_last = (rx_cnt_r == (pos_prof ? gw_pkg::TLG_LAST_POS : gw_pkg::TLG_LAST_DIST));
  wire tlg_done = link.rx_valid && tlg_last; // R10

  assign avs_readdata = avs_readdata_r;
  assign avs_waitrequest = avs_waitrequest_r;

  serial_engine u_engine (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .link(link.engine),
    .rxd(rxd),
    .txd(txd)
  );

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      avs_waitrequest_r <= 1'b1;
      avs_readdata_r <= 32'h0;
    end else begin
      avs_waitrequest_r <= !req_new;
      if (req_new && avs_read) avs_readdata_r <= rd_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cmd_mode_r <= gw_pkg::CMD_MODE_RST;
      profile_select_switch_r <= gw_pkg::PROFILE_RST;
      cmd_r <= 16'h0;
      prev_cmd_r <= 16'h0;
    end else begin
      prev_cmd_r <= cmd_r;
      if (wr_acc && sel_control && avs_byteenable[0]) begin
        cmd_mode_r <= avs_writedata[gw_pkg::CTRL_CMD_MODE_BIT];
        profile_select_switch_r <= avs_writedata[gw_pkg::CTRL_PROFILE_BIT];
      end
      if (wr_acc && sel_command && avs_byteenable[0]) cmd_r[7:0] <= avs_writedata[7:0];
      if (wr_acc && sel_command && avs_byteenable[1]) cmd_r[15:8] <= avs_writedata[15:8];
    end
  end

  // new edges are ORed in after the clear, so none is lost
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pend_r <= 16'h0;
    end else begin
      pend_r <= (pend_r & ~(seq_start_cmd ? first_hot : 16'h0)) | cmd_rise; // R16
    end
  end

  // polling runs from reset; any other positioning-profile command stops it until a position request, which wins when both rise in the same cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      auto_poll_r <= 1'b1; // R8
      poll_cnt_r <= '0;
      poll_pend_r <= 1'b0;
    end else begin
      if (pos_prof && poll_rise) auto_poll_r <= 1'b1; // R8
      else if (pos_prof && other_rise) auto_poll_r <= 1'b0; // R7
      if (!pos_prof || !auto_poll_r || poll_tick) poll_cnt_r <= '0;
      else poll_cnt_r <= poll_cnt_r + 1'b1;
      if (pos_prof && auto_poll_r && poll_tick) poll_pend_r <= 1'b1; // R7
      else if (seq_start_poll || !pos_prof || !auto_poll_r) poll_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      seq_st_r <= gw_pkg::SEQ_IDLE;
      sel_bit_r <= 4'h0;
      byte_idx_r <= 2'h0;
      seq_prof_r <= gw_pkg::PROFILE_POS;
    end else begin
      case (seq_st_r)
        gw_pkg::SEQ_IDLE: if (seq_start_cmd || seq_start_poll) begin
          sel_bit_r <= seq_start_cmd ? first_idx : gw_pkg::POLL_CMD_BIT; // R16 R7
          byte_idx_r <= 2'h0;
          seq_prof_r <= profile_select_switch_r;
          seq_st_r <= gw_pkg::SEQ_SEND;
        end
        gw_pkg::SEQ_SEND: if (tx_acc) begin
          byte_idx_r <= byte_idx_r + 2'h1;
          if (seq_last) seq_st_r <= gw_pkg::SEQ_IDLE;
        end
        default: seq_st_r <= gw_pkg::SEQ_IDLE;
      endcase
    end
  end

  // telegram capture; reading the upper word consumes it, a new telegram wins
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rx_sh_r <= 48'h0;
      tlg_r <= 48'h0;
      rx_cnt_r <= 3'h0;
      tlg_valid_r <= 1'b0;
    end else begin
      if (link.rx_valid) begin
        rx_sh_r <= rx_window;
        rx_cnt_r <= tlg_last ? 3'h0 : rx_cnt_r + 3'h1; // R10
      end
      if (tlg_done) tlg_r <= rx_window;
      if (tlg_done) tlg_valid_r <= 1'b1;
      else if (rd_acc && sel_rx_hi) tlg_valid_r <= 1'b0;
    end
  end
endmodule // sensor_gateway

// *** testbench/gw_props.sv ***
// port assertions for the sensor command gateway
`timescale 1ns/100ps
module gw_props #(
  parameter int POLL_CYCLES = 3000
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rxd,
  input wire logic txd
);
  int low_len;
  int high_len;
  int up_cnt;
  logic wr_seen_r;
  logic low_seen_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      low_len <= 0;
      high_len <= 0;
      up_cnt <= 0;
      wr_seen_r <= 1'b0;
      low_seen_r <= 1'b0;
    end else begin
      low_len <= txd ? 0 : low_len + 1;
      high_len <= txd ? high_len + 1 : 0;
      up_cnt <= up_cnt + 1;
      wr_seen_r <= wr_seen_r | avs_write;
      low_seen_r <= low_seen_r | !txd;
    end
  end
  a_ack_next: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  a_ack_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  a_no_stray_ack: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 5'h10
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_low_mult: assert property ($rose(txd) |-> (low_len % gw_pkg::DIV_POS == 0) ||
    (low_len % gw_pkg::DIV_DIST == 0)) else $error("low run not whole bit times");
  a_low_max: assert property (!txd |-> low_len < 9 * gw_pkg::DIV_DIST)
    else $error("line low beyond start plus eight bits");
  a_stop_min: assert property ($fell(txd) |-> high_len >= gw_pkg::DIV_POS)
    else $error("stop bit too short");
  a_quiet_poll: assert property (!wr_seen_r && up_cnt < POLL_CYCLES - 2 |-> txd)
    else $error("line active before poll period");
  a_poll_start: assert property (!wr_seen_r && up_cnt == POLL_CYCLES + 8 |-> low_seen_r)
    else $error("no poll after one period");
  cover property (avs_write && !avs_waitrequest);
  cover property (avs_read && !avs_waitrequest);
  cover property ($fell(txd));
endmodule // gw_props
bind sensor_gateway gw_props #(.POLL_CYCLES(POLL_CYCLES)) u_props (.core_clk(core_clk),
  .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd));

// *** testbench/sensor_model.sv ***
// serial sensor stand-in: decodes gateway bytes, sends bytes on request
`timescale 1ns/100ps
module sensor_model #(
  parameter int DIV = 2170
) (
  input wire logic core_clk,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  // line rests at mark level between bytes
  initial rxd = 1'b1;
  // raw byte, no framing characters, at the fixed DIV bit time (positioning baud in the bench)
  task automatic send_byte(input logic [7:0] b);
    @(posedge core_clk);
    rxd <= 1'b0;
    repeat (DIV) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (DIV) @(posedge core_clk);
    end
    rxd <= 1'b1;
    repeat (DIV) @(posedge core_clk);
  endtask
  always begin
    @(negedge txd);
    repeat (DIV / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge core_clk);
      sh[i] = txd;
    end
    repeat (DIV) @(posedge core_clk);
    // bad stop bit drops the byte, so the bench wait runs out
    if (txd) rx_q.push_back(sh);
  end
endmodule // sensor_model

// *** testbench/sensor_gateway_tb.sv ***
// self-checking bench for the sensor command gateway
`timescale 1ns/100ps
module sensor_gateway_tb;
  localparam int POLL = 3000;
  logic core_clk;
  logic reset_n;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rxd;
  logic txd;
  logic [31:0] rd;
  int mismatches;
  int n_compared;
  sensor_gateway #(.POLL_CYCLES(POLL)) uut (.core_clk(core_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd));
  sensor_model #(.DIV(gw_pkg::DIV_POS)) model (.core_clk(core_clk), .txd(txd), .rxd(rxd));
  always #4 core_clk = ~core_clk;
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic wait_bytes(input int n);
    int k;
    k = 0;
    while (model.rx_q.size() < n && k < 90000) begin
      @(posedge core_clk);
      k++;
    end
    if (model.rx_q.size() < n) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic t_reset_regs;
    bus(1'b0, gw_pkg::ADDR_CONTROL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, gw_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    bus(1'b0, 5'h14, 32'h0);
    chk(rd, 32'h0);
    $display("test reset_regs done");
  endtask
  task automatic t_poll_then_cmd;
    int k;
    k = 0;
    while (txd !== 1'b0 && k < POLL + 100) begin
      @(posedge core_clk);
      k++;
    end
    chk({31'h0, txd}, 32'h0);
    bus(1'b0, gw_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h3);
    // rise while mode is off must be forgotten, not replayed later
    bus(1'b1, gw_pkg::ADDR_COMMAND, 32'h1);
    bus(1'b1, gw_pkg::ADDR_CONTROL, 32'h1);
    bus(1'b1, gw_pkg::ADDR_COMMAND, 32'h0);
    bus(1'b1, gw_pkg::ADDR_COMMAND, 32'h21);
    // one received byte lands in the newest slot of the capture window
    model.send_byte(8'hA5);
    bus(1'b0, gw_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    bus(1'b0, gw_pkg::ADDR_RX_HI, 32'h0);
    chk(rd, 32'hA500);
    bus(1'b0, gw_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h0);
    wait_bytes(4);
    chk({24'h0, model.rx_q[0]}, 32'h08);
    chk({24'h0, model.rx_q[1]}, 32'h08);
    chk({24'h0, model.rx_q[2]}, 32'h01);
    chk({24'h0, model.rx_q[3]}, 32'h01);
    bus(1'b0, gw_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h0);
    repeat (3 * POLL) @(posedge core_clk);
    chk(model.rx_q.size(), 32'h4);
    $display("test poll_then_cmd done");
  endtask
  task automatic t_resume;
    bus(1'b1, gw_pkg::ADDR_CONTROL, 32'h3);
    bus(1'b0, gw_pkg::ADDR_CONTROL, 32'h0);
    chk(rd, 32'h3);
    bus(1'b1, gw_pkg::ADDR_CONTROL, 32'h1);
    // position request rise switches automatic polling back on
    bus(1'b1, gw_pkg::ADDR_COMMAND, 32'h8);
    bus(1'b0, gw_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    $display("test resume done");
  endtask
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    mismatches = 0;
    n_compared = 0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_reset_regs();
    t_poll_then_cmd();
    t_resume();
    tally_and_finish();
  end
endmodule // sensor_gateway_tb
